// *** verilog/wwdg_pkg.sv ***
/*
 * constants for the window watchdog: register offsets, field positions,
 * reset values and cycle counts.
 * assumes a 10 MHz system clock standing in for the oscillator clock.
 */
package wwdg_pkg;
    localparam logic [3:0]  CTRL_OFFSET      = 4'h0;
    localparam logic [3:0]  WINDOW_OFFSET    = 4'h4;
    localparam logic [3:0]  STATUS_OFFSET    = 4'h8;
    localparam int          ACT_BIT          = 7;
    localparam int          TOP_BIT          = 6;
    localparam logic [7:0]  CTRL_RESET       = 8'h7F;
    localparam logic [6:0]  WINDOW_RESET     = 7'h7F;
    localparam logic [6:0]  EXPIRE_FROM      = 7'h40;
    localparam int          PRESCALE_CYCLES  = 16384;
    localparam int          SHORT_WAKE       = 256;
    localparam int          LONG_WAKE        = 4096;
    localparam int          RST_PULSE_CYCLES = 300;
    localparam int          DELAY_W          = 13;

    typedef enum logic [1:0] {
        RUN,
        HALT_ONE,
        STOPPED,
        WAKE_DELAY
    } mode_t;
endpackage

// *** verilog/window_watchdog.sv ***
/*
 * window watchdog: free-running 7-bit downcounter with a refresh window,
 * a classic Wishbone register slave and halt handling.
 * assumes the cpu reports halt requests, wake events and slow/wait modes
 * as same-clock pulses or levels; reset_request_o drives the chip reset.
 */
// The address map and the Wishbone register port were chosen for this implementation.
// Overview of operation
// - counter decrements once every 16384 oscillator clocks from a free prescaler.
// - active and counter falls from 40h to 3Fh: drive reset low.
// - active and control written while counter above window: reset.
// - software mode starts disabled; activation bit set by software, cleared by reset.
// - hardware-enable option keeps watchdog active; activation bit ignored.
// - counter keeps counting even while the watchdog is disabled.
// - writing activation set with top bit clear gives a software reset.
// - active with reset-on-halt option and interrupt enable clear: halt instruction produces reset.
// - low six counter bits program timeout in 64 steps.
// - slow mode does not change counting rate.
// - wait mode does not change counting.
// - plain halt: no reset, one decrement, then stopped and harmless.
// - wake from halt by interrupt: resume after 256 or 4096 clocks.
// - reset ending halt returns to disabled state unless hardware-enabled.
// - active, interrupt enable clear and halt option set: reset instead of halt.
// - active halt stops counter without reset; interrupt restarts at once.
// - reset ending active halt: resume counting after 4096 clocks.
// - control and window registers reset to 7Fh.
// - control holds activation at bit 7, counter 6:0; window holds 6:0.
`timescale 1ns/1ps
module window_watchdog (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [3:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    input  wire logic        hw_enable_option_i,
    input  wire logic        halt_reset_option_i,
    input  wire logic        oscillator_interrupt_enable_i,
    input  wire logic        long_wake_delay_i,
    input  wire logic        halt_request_i,
    input  wire logic        wake_interrupt_i,
    input  wire logic        resumed_after_active_halt_i,
    input  wire logic        slow_mode_i,
    input  wire logic        wait_mode_i,
    output logic             reset_request_o,
    output logic             reset_pin_n_o,
    output logic             counter_stopped_o
);
    import wwdg_pkg::*;

    localparam logic [13:0] PRESCALE_LAST = 14'(PRESCALE_CYCLES - 1);
    localparam logic [8:0]  PULSE_LAST    = 9'(RST_PULSE_CYCLES - 1);

    typedef struct packed {
        logic              activation_bit;
        logic [6:0]        counter;
        logic [6:0]        window;
        logic [13:0]       prescale;
        mode_t             mode;
        logic [DELAY_W-1:0] delay;
        logic [8:0]        pulse;
        logic              pulse_on;
        logic              ack;
        logic [31:0]       rdata;
    } state_t;

    state_t s_q;
    state_t s_d;

    logic active;
    logic tick;
    logic ctrl_wr;
    logic win_wr;
    logic rd;
    logic fire;
    logic counting;

    function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
        hit = (a == off);
    endfunction

    // slow and wait modes never touch this path, so the rate is unchanged
    assign active   = hw_enable_option_i | s_q.activation_bit;
    assign counting = (s_q.mode == RUN) || (s_q.mode == HALT_ONE);
    assign tick     = (s_q.prescale == PRESCALE_LAST);
    // writes land on the edge that samples ack high, where the master sees them done
    assign ctrl_wr  = cyc_i & stb_i & we_i & s_q.ack & sel_i[0] & hit(adr_i, CTRL_OFFSET);
    assign win_wr   = cyc_i & stb_i & we_i & s_q.ack & sel_i[0] & hit(adr_i, WINDOW_OFFSET);
    assign rd       = cyc_i & stb_i & ~we_i & ~s_q.ack;

    always_comb begin
        s_d   = s_q;
        fire  = 1'b0;
        s_d.ack = cyc_i & stb_i & ~s_q.ack;

        // prescaler is free and never reset by a refresh, hence the min/max spread
        s_d.prescale = s_q.prescale + 14'h0001;
        if (counting && tick) begin
            s_d.counter = s_q.counter - 7'h01;
            if (active && s_q.counter == EXPIRE_FROM && s_q.mode == RUN) begin
                fire = 1'b1;
            end
            if (s_q.mode == HALT_ONE) begin
                s_d.mode = STOPPED;
            end
        end

        if (win_wr) begin
            s_d.window = dat_i[6:0];
        end
        if (ctrl_wr) begin
            if (active && s_q.counter > s_q.window) begin
                fire = 1'b1;
            end
            if (dat_i[ACT_BIT]) begin
                s_d.activation_bit = 1'b1;
            end
            if ((dat_i[ACT_BIT] | active) && !dat_i[TOP_BIT]) begin
                fire = 1'b1;
            end
            s_d.counter = dat_i[6:0];
        end

        unique case (s_q.mode)
            RUN: begin
                if (halt_request_i) begin
                    if (oscillator_interrupt_enable_i) begin
                        s_d.mode = STOPPED;
                    end else if (halt_reset_option_i && active) begin
                        fire = 1'b1;
                    end else begin
                        s_d.mode = HALT_ONE;
                    end
                end
            end
            HALT_ONE, STOPPED: begin
                if (wake_interrupt_i) begin
                    if (oscillator_interrupt_enable_i) begin
                        s_d.mode = RUN;
                    end else begin
                        s_d.mode  = WAKE_DELAY;
                        s_d.delay = long_wake_delay_i ? DELAY_W'(LONG_WAKE - 1)
                                                      : DELAY_W'(SHORT_WAKE - 1);
                    end
                end
            end
            WAKE_DELAY: begin
                if (s_q.delay == '0) begin
                    s_d.mode = RUN;
                end else begin
                    s_d.delay = s_q.delay - DELAY_W'(1);
                end
            end
        endcase

        if (fire && !s_q.pulse_on) begin
            s_d.pulse_on = 1'b1;
            s_d.pulse    = PULSE_LAST;
        end else if (s_q.pulse_on) begin
            if (s_q.pulse == '0) begin
                s_d.pulse_on = 1'b0;
            end else begin
                s_d.pulse = s_q.pulse - 9'h001;
            end
        end

        s_d.rdata = 32'h0000_0000;
        if (rd) begin
            if (hit(adr_i, CTRL_OFFSET)) begin
                s_d.rdata[7:0] = {s_q.activation_bit, s_q.counter};
            end else if (hit(adr_i, WINDOW_OFFSET)) begin
                s_d.rdata[6:0] = s_q.window;
            end else if (hit(adr_i, STATUS_OFFSET)) begin
                s_d.rdata[2:0] = {active, counting, s_q.pulse_on};
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q.activation_bit <= 1'b0;
            s_q.counter        <= CTRL_RESET[6:0];
            s_q.window         <= WINDOW_RESET;
            s_q.prescale       <= 14'h0000;
            // reset may end active halt; long delay taken as the safe figure
            s_q.mode           <= resumed_after_active_halt_i ? WAKE_DELAY : RUN;
            s_q.delay          <= DELAY_W'(LONG_WAKE - 1);
            s_q.pulse          <= 9'h000;
            s_q.pulse_on       <= 1'b0;
            s_q.ack            <= 1'b0;
            s_q.rdata          <= 32'h0000_0000;
        end else begin
            s_q <= s_d;
        end
    end

    assign dat_o             = s_q.rdata;
    assign ack_o             = s_q.ack;
    assign reset_request_o   = s_q.pulse_on;
    assign reset_pin_n_o     = ~s_q.pulse_on;
    assign counter_stopped_o = ~counting;
endmodule // window_watchdog

// *** bench/window_watchdog_asserts.sv ***
/* checker for window_watchdog: bus handshake and reset causes.
   bound to the design ports; everything sits in the clk_i domain. */
`timescale 1ns/1ps
module window_watchdog_asserts (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        we_i,
    input wire logic [3:0]  adr_i,
    input wire logic [3:0]  sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic        ack_o,
    input wire logic        hw_enable_option_i,
    input wire logic        halt_reset_option_i,
    input wire logic        oscillator_interrupt_enable_i,
    input wire logic        halt_request_i,
    input wire logic        reset_request_o,
    input wire logic        reset_pin_n_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire ctl_wr = cyc_i && stb_i && we_i && ack_o && sel_i[0] && adr_i == 4'h0;
    ack_once_a: assert property (ack_o |=> !ack_o) else $error("ack held too long");
    ack_answer_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("ack late");
    ack_cause_a: assert property (ack_o |-> $past(cyc_i && stb_i)) else $error("stray ack");
    hole_read_a: assert property (ack_o && $past(!we_i && adr_i == 4'hC) |-> dat_o == '0)
        else $error("unmapped read not zero");
    pin_level_a: assert property (reset_pin_n_o != reset_request_o)
        else $error("reset pin not inverse of request");
    soft_reset_a: assert property (ctl_wr && dat_i[7] && !dat_i[6] |-> ##[1:2] reset_request_o)
        else $error("software reset missing");
    hw_reset_a: assert property (ctl_wr && hw_enable_option_i && !dat_i[6] |-> ##[1:2] reset_request_o)
        else $error("forced-on reset missing");
    halt_reset_a: assert property (halt_request_i && hw_enable_option_i && halt_reset_option_i
        && !oscillator_interrupt_enable_i |-> ##[1:2] reset_request_o) else $error("halt reset missing");
    pulse_hold_a: assert property ($rose(reset_request_o) |-> reset_request_o[*8])
        else $error("reset pulse too short");
    cover property (ctl_wr);
    cover property ($rose(reset_request_o));
    cover property (ack_o && !we_i);
endmodule // window_watchdog_asserts

// *** bench/window_watchdog_test.sv ***
/* bench for window_watchdog: register access and every reset cause.
   drives all design ports itself over classic wishbone cycles. */
`timescale 1ns/1ps
module window_watchdog_test;
    import wwdg_pkg::*;
    logic        clk_i = '0, rst_i = '1, cyc_i = '0, stb_i = '0, we_i = '0;
    logic [3:0]  adr_i = '0, sel_i = '0;
    logic [31:0] dat_i = '0, dat_o, rdat;
    logic        ack_o, hw_en = '0, halt_opt = '0, oscillator_interrupt_enable = '0, halt_i = '0, wake_i = '0;
    logic        rr_o, pin_n_o, stop_o;
    logic        slow_i = '0, wait_i = '0, resumed_i = '0, long_i = '0;
    int          n_mismatch = 0, n_tests = 0, cyc_cnt = 0, w;
    window_watchdog u_window_watchdog (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i,
        .dat_i, .dat_o, .ack_o, .hw_enable_option_i(hw_en), .halt_reset_option_i(halt_opt),
        .oscillator_interrupt_enable_i(oscillator_interrupt_enable), .long_wake_delay_i(long_i), .halt_request_i(halt_i),
        .wake_interrupt_i(wake_i), .resumed_after_active_halt_i(resumed_i), .slow_mode_i(slow_i),
        .wait_mode_i(wait_i), .reset_request_o(rr_o), .reset_pin_n_o(pin_n_o),
        .counter_stopped_o(stop_o));
    initial forever #50 clk_i = ~clk_i;
    // ceiling covers the expiry, the stopped-halt and the wake-delay waits with margin
    always @(posedge clk_i) if (++cyc_cnt == 90000) begin
        n_mismatch++;
        results();
    end
    task results;
        if (n_mismatch == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task cmp(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task bus(input logic we, input logic [3:0] a, input logic [7:0] d);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= we;
        adr_i <= a;
        sel_i <= 4'hF;
        dat_i <= {24'h0, d};
        @(posedge clk_i);
        while (ack_o !== 1'b1) @(posedge clk_i);
        rdat = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge clk_i);
    endtask
    // waits for the reset request, then resets the block as the chip would
    task fire(input int lo, input int hi);
        w = 0;
        while (rr_o !== 1'b1 && w <= hi) begin
            @(posedge clk_i);
            w++;
        end
        cmp(w > lo && w <= hi, 32'h1);
        cmp(pin_n_o, 32'h0);
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
    endtask
    task halt_pulse;
        halt_i <= 1'b1;
        @(posedge clk_i);
        halt_i <= 1'b0;
    endtask
    task wake_pulse;
        wake_i <= 1'b1;
        @(posedge clk_i);
        wake_i <= 1'b0;
    endtask
    task wait_stop(input int hi);
        w = 0;
        while (stop_o !== 1'b1 && w <= hi) begin
            @(posedge clk_i);
            w++;
        end
    endtask
    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        bus(1'b0, 4'h0, 8'h00);
        cmp(rdat, 32'h7F);
        bus(1'b0, 4'h4, 8'h00);
        cmp(rdat, 32'h7F);
        bus(1'b0, 4'hC, 8'h00);
        cmp(rdat, 32'h0);
        bus(1'b1, 4'h4, 8'h50);
        bus(1'b0, 4'h4, 8'h00);
        cmp(rdat, 32'h50);
        bus(1'b1, 4'h0, 8'h05);
        bus(1'b0, 4'h0, 8'h00);
        // a prescaler tick may land in between, so the lowest bit is left out
        cmp(rdat[7:1], 32'h02);
        cmp(rr_o, 32'h0);
        bus(1'b1, 4'h0, 8'hC5);
        bus(1'b1, 4'h0, 8'h45);
        bus(1'b0, 4'h0, 8'h00);
        cmp(rdat[7:1], 32'h62);
        bus(1'b1, 4'h4, 8'h30);
        bus(1'b1, 4'h0, 8'hC5);
        fire(-1, 3);
        bus(1'b0, 4'h0, 8'h00);
        cmp(rdat[7], 32'h0);
        bus(1'b1, 4'h0, 8'h80);
        fire(-1, 3);
        slow_i <= 1'b1;
        wait_i <= 1'b1;
        bus(1'b1, 4'h0, 8'hC1);
        fire(16380, 32780);
        hw_en <= 1'b1;
        bus(1'b1, 4'h0, 8'h01);
        fire(-1, 3);
        halt_opt <= 1'b1;
        halt_pulse();
        fire(-1, 3);
        halt_opt <= 1'b0;
        oscillator_interrupt_enable <= 1'b1;
        halt_pulse();
        repeat (3) @(posedge clk_i);
        cmp(stop_o, 32'h1);
        cmp(rr_o, 32'h0);
        wake_pulse();
        repeat (2) @(posedge clk_i);
        cmp(stop_o, 32'h0);
        oscillator_interrupt_enable <= 1'b0;
        bus(1'b1, 4'h0, 8'hC5);
        halt_pulse();
        wait_stop(16400);
        cmp(w > 1 && w <= 16385, 32'h1);
        bus(1'b0, 4'h0, 8'h00);
        cmp(rdat, 32'hC4);
        repeat (16400) @(posedge clk_i);
        bus(1'b0, 4'h0, 8'h00);
        cmp(rdat, 32'hC4);
        cmp(rr_o, 32'h0);
        wake_pulse();
        repeat (250) @(posedge clk_i);
        cmp(stop_o, 32'h1);
        repeat (10) @(posedge clk_i);
        cmp(stop_o, 32'h0);
        resumed_i <= 1'b1;
        rst_i     <= 1'b1;
        repeat (6) @(posedge clk_i);
        rst_i     <= 1'b0;
        resumed_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        cmp(stop_o, 32'h1);
        repeat (4100) @(posedge clk_i);
        cmp(stop_o, 32'h0);
        results();
    end
endmodule // window_watchdog_test
bind window_watchdog window_watchdog_asserts u_window_watchdog_asserts (.clk_i, .rst_i, .cyc_i,
    .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .hw_enable_option_i,
    .halt_reset_option_i, .oscillator_interrupt_enable_i, .halt_request_i, .reset_request_o,
    .reset_pin_n_o);
